// ===== mhcp_pkg.sv
// package: constants and carrier types of the motion host command port
package mhcp_pkg;
  // word widths
  localparam int DATA_W = 16;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 3;
  localparam int BE_W = 4;
  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_MOVE = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_ERROR = 3'h3;
  // communication status bit positions
  localparam int STATUS_W = 6;
  localparam int CSR_RX_READY = 0;
  localparam int CSR_RTS = 1;
  localparam int CSR_PKT_ERR = 2;
  localparam int CSR_ERR_MSG = 3;
  localparam int CSR_CMD_FULL = 4;
  localparam int CSR_STACK_FULL = 5;
  // queue and stack depths, axis count
  localparam int CMD_FIFO_DEPTH = 16;
  localparam int RET_FIFO_DEPTH = 26;
  localparam int ERR_STACK_DEPTH = 30;
  localparam int AXES = 6;
  // packet framing and command decoding
  localparam logic [15:0] PKT_TERMINATOR = 16'hA5A5;
  localparam logic [7:0] CMD_ID_NONE = 8'h00;
  localparam logic [7:0] RES_ID_NONE = 8'h00;
  localparam int STORE_BIT = 7;
  localparam logic [6:0] CMD_ID_MAX = 7'h5F;
  // error codes
  localparam logic [7:0] ERR_CODE_DATA = 8'h01;
  localparam logic [7:0] ERR_CODE_RET_FULL = 8'h02;
  // carriers
  typedef struct packed {
    logic [7:0] command_identifier;
    logic [7:0] resource_identifier;
    logic [15:0] data;
  } mhcp_cmd_t;
  typedef struct packed {
    logic [7:0] command_identifier;
    logic [7:0] resource_identifier;
    logic [7:0] code;
  } mhcp_err_t;
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} mhcp_bus_t;
  typedef enum logic [1:0] {RX_IDENT, RX_DATA, RX_TERM} mhcp_rx_t;
endpackage : mhcp_pkg

// ===== mhcp_mem.sv
// file: small word memory with registered read data
`timescale 1ns/1ns
module mhcp_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // storage carries no reset, it is never read before written
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read-during-write returns the old word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : mhcp_mem

// ===== mhcp_fifo.sv
// file: first-in-first-out queue over the small memory
`timescale 1ns/1ns
module mhcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 26,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  output logic full,
  // drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic head_valid,
  output logic [CNT_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic valid;
  } mhcp_fifo_st_t;

  mhcp_fifo_st_t st_reg;
  mhcp_fifo_st_t st_next;
  logic do_push;
  logic do_pop;

  // wrap a pointer at the depth, which need not be a power of two
  function automatic logic [PTR_W-1:0] mhcp_ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : mhcp_ptr_inc

  // pointer and count update; head valid waits out the memory latency
  always_comb begin
    st_next = st_reg;
    do_push = push && (st_reg.count != CNT_FULL);
    do_pop = pop && st_reg.valid;
    if (do_push) begin
      st_next.wr_ptr = mhcp_ptr_inc(st_reg.wr_ptr);
    end
    if (do_pop) begin
      st_next.rd_ptr = mhcp_ptr_inc(st_reg.rd_ptr);
    end
    if (do_push && !do_pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (!do_push && do_pop) begin
      st_next.count = st_reg.count - 1'b1;
    end
    // the word being written cannot be read back in the same edge
    st_next.valid = (st_next.count != '0) && !(do_push && (st_reg.count == CNT_W'(do_pop)));
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // read address looks ahead so the new head is ready one edge later
  mhcp_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(PTR_W)) u_mem (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_en(do_push),
    .wr_addr(st_reg.wr_ptr),
    .wr_data(push_data),
    .rd_addr(st_next.rd_ptr),
    .rd_data(head_data)
  );

  assign full = (st_reg.count == CNT_FULL);
  assign head_valid = st_reg.valid;
  assign count = st_reg.count;
endmodule : mhcp_fifo

// ===== mhcp_port.sv
// file: host command port top with bus slave, packet parser, queues and error stack
`timescale 1ns/1ns
module mhcp_port
  import mhcp_pkg::*;
#(
  parameter int N_AXES = AXES,
  parameter int CMD_DEPTH = CMD_FIFO_DEPTH,
  parameter int RET_DEPTH = RET_FIFO_DEPTH,
  parameter int ERR_DEPTH = ERR_STACK_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BE_W-1:0] avs_byteenable,
  input wire logic [BUS_W-1:0] avs_writedata,
  output logic [BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // command hand-off to the executor
  output logic exec_valid,
  output mhcp_cmd_t exec_cmd,
  output logic exec_store,
  input wire logic exec_ready,
  // errors found by the executor
  input wire logic error_in_valid,
  input wire mhcp_err_t error_in_entry,
  // return words requested by host commands
  input wire logic return_valid,
  input wire logic [DATA_W-1:0] return_word,
  // axis completion levels
  input wire logic [N_AXES-1:0] move_done_in
);
  localparam int SP_W = $clog2(ERR_DEPTH + 1);
  localparam int MEM_AW = $clog2(ERR_DEPTH);
  localparam int CMD_CNT_W = $clog2(CMD_DEPTH + 1);
  localparam int RET_CNT_W = $clog2(RET_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(ERR_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);
  localparam logic [SP_W-1:0] SP_TWO = SP_W'(2);

  typedef struct packed {
    mhcp_bus_t bus;
    logic waitreq;
    logic [BUS_W-1:0] rdata;
    mhcp_rx_t rx;
    logic [7:0] rx_cmd;
    logic [7:0] rx_res;
    logic [DATA_W-1:0] rx_data;
    logic pkt_err;
    logic ovf_pend;
    logic [SP_W-1:0] sp;
    mhcp_err_t top;
    mhcp_err_t pushed;
    logic just_pushed;
    logic [N_AXES-1:0] move_done;
    logic exec_valid;
    mhcp_cmd_t exec_cmd;
    logic exec_store;
  } mhcp_state_t;

  mhcp_state_t st_reg;
  mhcp_state_t st_next;

  // queue and stack wiring
  logic take;
  logic wr_lanes;
  logic clear_pkt;
  logic pkt_err_set;
  logic cmd_push;
  logic cmd_pop;
  logic cmd_full;
  logic cmd_head_valid;
  mhcp_cmd_t cmd_head;
  mhcp_cmd_t cmd_new;
  logic [CMD_CNT_W-1:0] cmd_count;
  logic ret_push;
  logic ret_pop;
  logic ret_full;
  logic ret_head_valid;
  logic [DATA_W-1:0] ret_head;
  logic [RET_CNT_W-1:0] ret_count;
  logic ovf;
  logic ovf_taken;
  logic stk_push;
  logic stk_pop;
  logic stk_wr;
  mhcp_err_t push_entry;
  mhcp_err_t stk_rdata;
  mhcp_err_t below;
  logic [STATUS_W-1:0] status_vec;

  // live status word; ready drops while the command queue is full
  always_comb begin
    status_vec = '0;
    status_vec[CSR_RX_READY] = !cmd_full;
    status_vec[CSR_RTS] = (ret_count != '0);
    status_vec[CSR_PKT_ERR] = st_reg.pkt_err;
    status_vec[CSR_ERR_MSG] = (st_reg.sp != '0) || st_reg.ovf_pend;
    status_vec[CSR_CMD_FULL] = cmd_full;
    status_vec[CSR_STACK_FULL] = (st_reg.sp == SP_FULL);
  end

  // bus, parser, dispatch and stack next state
  always_comb begin
    st_next = st_reg;
    st_next.bus = BUS_IDLE;
    st_next.waitreq = 1'b1;
    st_next.move_done = move_done_in;
    take = (st_reg.bus == BUS_IDLE) && (avs_read || avs_write);
    wr_lanes = (avs_byteenable[1:0] == 2'b11);
    clear_pkt = 1'b0;
    pkt_err_set = 1'b0;
    cmd_push = 1'b0;
    cmd_pop = 1'b0;
    ret_pop = 1'b0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    stk_wr = 1'b0;
    ovf_taken = 1'b0;
    push_entry = '0;
    cmd_new = '{command_identifier: st_reg.rx_cmd, resource_identifier: st_reg.rx_res, data: st_reg.rx_data};
    below = st_reg.just_pushed ? st_reg.pushed : stk_rdata;
    // every request is answered one cycle after it is taken
    if (take) begin
      st_next.bus = BUS_ACK;
      st_next.waitreq = 1'b0;
      st_next.rdata = '0;
      if (avs_read) begin
        case (avs_address)
          ADDR_DATA: begin
            // host pulls return words in arrival order
            if (ret_head_valid) begin
              st_next.rdata = {{(BUS_W - DATA_W){1'b0}}, ret_head};
              ret_pop = 1'b1;
            end
          end
          ADDR_STATUS: begin
            st_next.rdata = {{(BUS_W - STATUS_W){1'b0}}, status_vec};
            clear_pkt = 1'b1;
          end
          ADDR_MOVE: begin
            st_next.rdata = {{(BUS_W - N_AXES){1'b0}}, st_reg.move_done};
          end
          ADDR_ERROR: begin
            if (st_reg.sp != '0) begin
              st_next.rdata = {8'h00, st_reg.top};
              stk_pop = 1'b1;
            end
          end
          default: begin
            st_next.rdata = '0;
          end
        endcase
      end else if ((avs_address == ADDR_DATA) && wr_lanes) begin
        // framing: identifier, one data word, terminator
        case (st_reg.rx)
          RX_IDENT: begin
            if (avs_writedata[15:8] == CMD_ID_NONE) begin
              pkt_err_set = 1'b1;
            end else begin
              st_next.rx_cmd = avs_writedata[15:8];
              st_next.rx_res = avs_writedata[7:0];
              st_next.rx = RX_DATA;
            end
          end
          RX_DATA: begin
            st_next.rx_data = avs_writedata[DATA_W-1:0];
            st_next.rx = RX_TERM;
          end
          RX_TERM: begin
            st_next.rx = RX_IDENT;
            // a packet sent against a full queue is dropped as an error too
            if ((avs_writedata[DATA_W-1:0] == PKT_TERMINATOR) && !cmd_full) begin
              cmd_push = 1'b1;
            end else begin
              pkt_err_set = 1'b1;
            end
          end
          default: begin
            st_next.rx = RX_IDENT;
          end
        endcase
      end
    end
    // set wins over the clear that a status read makes
    st_next.pkt_err = pkt_err_set || (st_reg.pkt_err && !clear_pkt);

    // executor hand-off; errors have the stack before new commands
    if (st_reg.exec_valid && exec_ready) begin
      st_next.exec_valid = 1'b0;
    end
    if (error_in_valid) begin
      stk_push = 1'b1;
      push_entry = error_in_entry;
    end else if (st_reg.ovf_pend) begin
      stk_push = 1'b1;
      ovf_taken = 1'b1;
      push_entry = '{command_identifier: CMD_ID_NONE, resource_identifier: RES_ID_NONE, code: ERR_CODE_RET_FULL};
    end else if (cmd_head_valid && (!st_reg.exec_valid || exec_ready)) begin
      cmd_pop = 1'b1;
      if (cmd_head.command_identifier[6:0] > CMD_ID_MAX) begin
        stk_push = 1'b1;
        push_entry = '{command_identifier: cmd_head.command_identifier,
                       resource_identifier: cmd_head.resource_identifier, code: ERR_CODE_DATA};
      end else begin
        st_next.exec_valid = 1'b1;
        st_next.exec_cmd = cmd_head;
        st_next.exec_store = cmd_head.command_identifier[STORE_BIT];
      end
    end
    // overflow stays pending for as many cycles as an executor error has the stack
    st_next.ovf_pend = ovf || (st_reg.ovf_pend && !ovf_taken);

    // stack: top in a register, older entries in memory
    st_next.just_pushed = 1'b0;
    if (stk_push && stk_pop) begin
      st_next.top = push_entry;
    end else if (stk_push && (st_reg.sp != SP_FULL)) begin
      if (st_reg.sp != '0) begin
        stk_wr = 1'b1;
        st_next.pushed = st_reg.top;
        st_next.just_pushed = 1'b1;
      end
      st_next.top = push_entry;
      st_next.sp = st_reg.sp + 1'b1;
    end else if (stk_pop) begin
      st_next.top = (st_reg.sp > SP_ONE) ? below : '0;
      st_next.sp = st_reg.sp - 1'b1;
    end
  end

  // return words enter unless the queue is full
  assign ret_push = return_valid && !ret_full;
  assign ovf = return_valid && ret_full;

  // the single state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // command queue holds sixteen whole packets
  mhcp_fifo #(.WIDTH($bits(mhcp_cmd_t)), .DEPTH(CMD_DEPTH), .CNT_W(CMD_CNT_W)) u_cmd_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .push(cmd_push),
    .push_data(cmd_new),
    .full(cmd_full),
    .pop(cmd_pop),
    .head_data(cmd_head),
    .head_valid(cmd_head_valid),
    .count(cmd_count)
  );

  // return queue may hold several return words left for later
  mhcp_fifo #(.WIDTH(DATA_W), .DEPTH(RET_DEPTH), .CNT_W(RET_CNT_W)) u_return_data_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .push(ret_push),
    .push_data(return_word),
    .full(ret_full),
    .pop(ret_pop),
    .head_data(ret_head),
    .head_valid(ret_head_valid),
    .count(ret_count)
  );

  // entries below the top; old top goes to slot sp-1
  mhcp_mem #(.WIDTH($bits(mhcp_err_t)), .DEPTH(ERR_DEPTH), .AW(MEM_AW)) u_err_mem (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_en(stk_wr),
    .wr_addr(MEM_AW'(st_reg.sp - SP_ONE)),
    .wr_data(st_reg.top),
    .rd_addr(MEM_AW'(st_next.sp - SP_TWO)),
    .rd_data(stk_rdata)
  );

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign exec_valid = st_reg.exec_valid;
  assign exec_cmd = st_reg.exec_cmd;
  assign exec_store = st_reg.exec_store;

  // checks on the port behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence seq_term_word;
    take && avs_write && (avs_address == ADDR_DATA) && wr_lanes && (st_reg.rx == RX_TERM);
  endsequence
  sequence seq_good_term;
    seq_term_word ##0 ((avs_writedata[15:0] == PKT_TERMINATOR) && !cmd_full && !cmd_pop);
  endsequence
  sequence seq_bad_term;
    seq_term_word ##0 ((avs_writedata[15:0] != PKT_TERMINATOR) && !cmd_pop);
  endsequence
  sequence seq_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  chk_bus_answer_once: assert property (take |=> seq_answer)
    else $error("request not answered in exactly one cycle");
  chk_good_packet_stored: assert property (seq_good_term |=> cmd_count == $past(cmd_count) + 1'b1)
    else $error("good packet not stored in command queue");
  chk_bad_term_dropped: assert property (seq_bad_term |=> st_reg.pkt_err && $stable(cmd_count))
    else $error("bad terminator not flagged or packet stored");
  // full flag must agree with the queue's own count, not only with the status bits
  chk_ready_when_full: assert property (cmd_full |-> !status_vec[CSR_RX_READY]
    && status_vec[CSR_CMD_FULL] && (cmd_count == CMD_CNT_W'(CMD_DEPTH)))
    else $error("ready shown while command queue full");
  chk_return_ready_bit: assert property ((return_valid && !ret_full) |=> status_vec[CSR_RTS])
    else $error("return_data_available_flag not set after return word");
  chk_overflow_flagged: assert property ((return_valid && ret_full) |=> status_vec[CSR_ERR_MSG] [*2])
    else $error("return overflow not flagged");
  chk_stack_newest_top: assert property ((stk_push && !stk_pop && (st_reg.sp != SP_FULL))
    |=> (st_reg.top == $past(push_entry)) && status_vec[CSR_ERR_MSG])
    else $error("pushed error not on top of stack");
  chk_stack_full_drop: assert property ((stk_push && !stk_pop && (st_reg.sp == SP_FULL))
    |=> (st_reg.sp == SP_FULL) && $stable(st_reg.top))
    else $error("full stack accepted an entry");
  chk_stack_pop_order: assert property ((stk_pop && !stk_push && (st_reg.sp > SP_ONE) && !st_reg.just_pushed)
    |=> st_reg.top == $past(stk_rdata))
    else $error("pop did not expose the next older entry");
  chk_exec_held: assert property ((st_reg.exec_valid && !exec_ready) |=> exec_valid && $stable(exec_cmd))
    else $error("command to executor dropped before taken");
  chk_pkt_err_sticky: assert property ((st_reg.pkt_err && !clear_pkt) |=> st_reg.pkt_err)
    else $error("packet-error bit cleared without status read");
endmodule : mhcp_port

// ===== mhcp_exec_model.sv
// file: executor model that takes commands offered by the port
`timescale 1ns/1ns
module mhcp_exec_model
  import mhcp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // command hand-off
  input wire logic exec_valid,
  input wire mhcp_cmd_t exec_cmd,
  input wire logic exec_store,
  output logic exec_ready,
  // pacing set by the bench
  input wire logic stall,
  input wire logic slow,
  // record of accepted commands
  output logic [7:0] taken_count,
  output mhcp_cmd_t last_cmd,
  output logic last_store
);
  logic [1:0] phase_reg;
  // slow mode accepts one cycle in four, so offers must hold
  assign exec_ready = !stall && (!slow || phase_reg == 2'h0);
  // count and keep what was accepted
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= 2'h0;
      taken_count <= 8'h00;
      last_cmd <= '0;
      last_store <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (exec_valid && exec_ready) begin
        taken_count <= taken_count + 8'h01;
        last_cmd <= exec_cmd;
        last_store <= exec_store;
      end
    end
  end
endmodule : mhcp_exec_model

// ===== tb.sv
// file: self-checking bench of the host command port
`timescale 1ns/1ns
module tb;
  import mhcp_pkg::*;
  typedef struct packed {
    logic [15:0] ident;
    logic [15:0] data;
    logic [15:0] term;
    logic perr;
    logic taken;
    logic [31:0] err;
  } mhcp_row_t;
  localparam logic [31:0] S_RX_READY = 32'h00000001;
  localparam logic [31:0] S_RTS = 32'h00000002;
  localparam logic [31:0] S_PERR = 32'h00000004;
  localparam logic [31:0] S_EMSG = 32'h00000008;
  localparam logic [31:0] S_CFULL = 32'h00000010;
  localparam logic [31:0] S_SFULL = 32'h00000020;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BE_W-1:0] avs_byteenable = '0;
  logic [BUS_W-1:0] avs_writedata = '0;
  logic [BUS_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic exec_valid;
  logic exec_ready;
  logic exec_store;
  mhcp_cmd_t exec_cmd;
  mhcp_cmd_t last_cmd;
  logic error_in_valid = 1'b0;
  mhcp_err_t error_in_entry = '0;
  logic return_valid = 1'b0;
  logic [DATA_W-1:0] return_word = '0;
  logic [5:0] move_done_in = '0;
  logic stall = 1'b0;
  logic slow = 1'b1;
  logic [7:0] taken_count;
  logic [7:0] base;
  logic last_store;
  logic [BUS_W-1:0] rd_q;
  int bad_count = 0;
  int n_compared = 0;
  int n;
  mhcp_row_t rows [5] = '{
    '{16'h1203, 16'h1111, 16'hA5A5, 1'b0, 1'b1, 32'h00000000},
    '{16'h9204, 16'h2222, 16'hA5A5, 1'b0, 1'b1, 32'h00000000},
    '{16'h1305, 16'h3333, 16'h5A5A, 1'b1, 1'b0, 32'h00000000},
    '{16'h6007, 16'h4444, 16'hA5A5, 1'b0, 1'b0, 32'h00600701},
    '{16'h5F01, 16'h5555, 16'hA5A5, 1'b0, 1'b1, 32'h00000000}
  };

  // 4 ns clock
  always #2 sys_clk = ~sys_clk;

  mhcp_port DUT (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_store(exec_store), .exec_ready(exec_ready),
    .error_in_valid(error_in_valid), .error_in_entry(error_in_entry), .return_valid(return_valid),
    .return_word(return_word), .move_done_in(move_done_in));

  mhcp_exec_model exec_model (.sys_clk(sys_clk), .reset(reset), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_store(exec_store), .exec_ready(exec_ready), .stall(stall), .slow(slow),
    .taken_count(taken_count), .last_cmd(last_cmd), .last_store(last_store));

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask : check

  // one bus cycle; request held until waitrequest is seen low at an edge
  task xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d, input logic [BE_W-1:0] be);
    int w;
    w = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && w < 40) begin
      @(posedge sys_clk);
      w++;
    end
    if (w >= 40) bad_count++;
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  task rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000, 4'hF);
    check(nm, rd_q, exp);
  endtask : rd

  task wr(input logic [15:0] d);
    xfer(1'b1, ADDR_DATA, {16'h0000, d}, 4'hF);
  endtask : wr

  task pkt(input logic [15:0] ident, input logic [15:0] d, input logic [15:0] term);
    wr(ident);
    wr(d);
    wr(term);
  endtask : pkt

  // bounded wait for the executor to have taken a given total
  task wait_taken(input logic [7:0] target, input int lim);
    int w;
    w = 0;
    while (taken_count !== target && w < lim) begin
      @(posedge sys_clk);
      w++;
    end
  endtask : wait_taken

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // watchdog cuts a hang short
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    check("wait_rst", avs_waitrequest, 1'b1);
    check("valid_rst", exec_valid, 1'b0);
    check("rdata_rst", avs_readdata, 32'h00000000);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd("status_rst", ADDR_STATUS, S_RX_READY);
    // packets from the table, including a bad terminator and an out-of-range identifier
    foreach (rows[i]) begin
      base = taken_count;
      pkt(rows[i].ident, rows[i].data, rows[i].term);
      wait_taken(base + 8'(rows[i].taken), 100);
      check("taken", taken_count, base + 8'(rows[i].taken));
      if (rows[i].taken) begin
        check("cmd", last_cmd, {rows[i].ident, rows[i].data});
        check("store", last_store, rows[i].ident[15]);
      end
      rd("status", ADDR_STATUS,
        S_RX_READY | (rows[i].perr ? S_PERR : '0) | (rows[i].err != 0 ? S_EMSG : '0));
      rd("stack", ADDR_ERROR, rows[i].err);
    end
    // zero identifier, then half-enabled write, then a good packet
    wr(16'h0009);
    rd("perr_id0", ADDR_STATUS, S_RX_READY | S_PERR);
    xfer(1'b1, ADDR_DATA, 32'h00001234, 4'hC);
    xfer(1'b1, ADDR_STATUS, 32'h000000FF, 4'hF);
    base = taken_count;
    pkt(16'h1206, 16'h7777, 16'hA5A5);
    wait_taken(base + 8'h01, 100);
    check("cmd_after", last_cmd, 32'h12067777);
    rd("status_ro", ADDR_STATUS, S_RX_READY);
    // fill the command queue with the executor stalled; one more sits in the hand-off register
    stall <= 1'b1;
    base = taken_count;
    n = 0;
    rd_q = S_RX_READY;
    while (rd_q[CSR_RX_READY] === 1'b1 && n < 20) begin
      pkt(16'h2101, 16'(n), 16'hA5A5);
      n++;
      xfer(1'b0, ADDR_STATUS, 32'h00000000, 4'hF);
    end
    check("cmd_depth", n, 32'(CMD_FIFO_DEPTH + 1));
    check("full_status", rd_q, S_CFULL);
    pkt(16'h2101, 16'h00FF, 16'hA5A5);
    rd("over_perr", ADDR_STATUS, S_CFULL | S_PERR);
    stall <= 1'b0;
    wait_taken(base + 8'(n), 200);
    check("drained", taken_count, base + 8'(n));
    check("last_fifo", last_cmd, {16'h2101, 16'(n - 1)});
    rd("ready_back", ADDR_STATUS, S_RX_READY);
    // error stack overfilled back to back
    for (int i = 1; i <= 32; i++) begin
      error_in_valid <= 1'b1;
      error_in_entry <= {8'h40, 8'h01, 8'(i)};
      @(posedge sys_clk);
    end
    error_in_valid <= 1'b0;
    rd("stack_full", ADDR_STATUS, S_RX_READY | S_EMSG | S_SFULL);
    for (int k = 30; k >= 1; k--) begin
      rd("stack_pop", ADDR_ERROR, {8'h00, 8'h40, 8'h01, 8'(k)});
    end
    rd("stack_empty", ADDR_ERROR, 32'h00000000);
    rd("emsg_clear", ADDR_STATUS, S_RX_READY);
    // return queue filled past its depth
    for (int i = 0; i <= 26; i++) begin
      return_valid <= 1'b1;
      return_word <= 16'hC000 + 16'(i);
      @(posedge sys_clk);
    end
    return_valid <= 1'b0;
    rd("ret_status", ADDR_STATUS, S_RX_READY | S_RTS | S_EMSG);
    for (int i = 0; i < 26; i++) begin
      rd("ret_word", ADDR_DATA, 32'h0000C000 + 32'(i));
    end
    rd("ret_done", ADDR_STATUS, S_RX_READY | S_EMSG);
    rd("ret_empty", ADDR_DATA, 32'h00000000);
    rd("ret_ovf", ADDR_ERROR, 32'h00000002);
    // move-done levels and an unmapped address
    move_done_in <= 6'h2A;
    @(posedge sys_clk);
    rd("move_done", ADDR_MOVE, 32'h0000002A);
    rd("unmapped", 3'h5, 32'h00000000);
    // mid-run reset with a command held for the executor and an error stacked
    stall <= 1'b1;
    pkt(16'h1208, 16'h8888, 16'hA5A5);
    error_in_valid <= 1'b1;
    error_in_entry <= {8'h41, 8'h02, 8'h03};
    @(posedge sys_clk);
    error_in_valid <= 1'b0;
    reset <= 1'b1;
    @(posedge sys_clk);
    check("wait_rst2", avs_waitrequest, 1'b1);
    check("valid_rst2", exec_valid, 1'b0);
    reset <= 1'b0;
    stall <= 1'b0;
    rd("status_rst2", ADDR_STATUS, S_RX_READY);
    rd("stack_rst2", ADDR_ERROR, 32'h00000000);
    check("taken_rst2", taken_count, 8'h00);
    summarize();
  end
endmodule : tb
